/* rtl/lcs_sequencer.sv */
/*
 * Charge sequencer of a single-cell Li-ion linear charger with power path, with an AHB-Lite
 * register slave and one level interrupt.
 * Assumes analog comparators arrive as synchronous levels on core_clk, and that resetn is
 * released once either supply has cleared its undervoltage lockout.
 */
`timescale 1ns/100ps
`include "lcs_regs.svh"

module lcs_sequencer #(
   parameter int unsigned IMMUNITY_CYC = `LCS_IMMUNITY_CYC,
   parameter int unsigned TERM_DLY_CYC = `LCS_TERM_DLY_CYC,
   parameter logic [39:0] PRE_TMO_CYC  = 40'(`LCS_PRE_TMO_CYC)
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        vin_ovp,
   input  wire logic        vin_uvlo,
   input  wire logic        vbatt_above_pre,
   input  wire logic        vbatt_at_reg,
   input  wire logic        vbatt_below_rech,
   input  wire logic        vbatt_ov,
   input  wire logic        ibatt_below_term,
   input  wire logic        ibatt_below_term_hys,
   input  wire logic        ntc_fault,
   output logic             input_pass_fet,
   output logic             batt_chg_fet_en,
   output logic      [1:0]  pre_current_sel,
   output logic      [4:0]  cc_current_sel,
   output logic      [5:0]  full_charge_voltage,
   output logic      [2:0]  chg_state,
   output logic             chg_done,
   output logic             timeout_fault,
   output logic             batt_ov_fault,
   output logic             irq
);

   lcs_pkg::lcs_state_t s_ff;
   lcs_pkg::lcs_state_t nxt_s;

   logic in_in_window;
   logic input_isolate_ctl;
   logic charge_disable_n;
   logic keep_cv_after_done;
   logic term_en;
   logic ahb_go;
   logic new_trigger;
   logic auto_rech;
   logic cycle_ok;
   logic [3:0] evt;

   // The charge disable bit is active high; the signal name keeps the mnemonic of the pin.
   assign input_isolate_ctl  = s_ff.chg_cfg[`LCS_ISO_BIT];
   assign charge_disable_n   = s_ff.chg_cfg[`LCS_CDIS_BIT];
   assign keep_cv_after_done = s_ff.term_cfg[`LCS_KEEP_CV_BIT];
   assign term_en            = s_ff.term_cfg[`LCS_TERM_EN_BIT];
   assign in_in_window       = !vin_ovp && !vin_uvlo;
   assign ahb_go             = hsel && hready && htrans[1];

   // Auto-recharge is only legal with termination on and current cut at completion.
   assign auto_rech = (s_ff.chg == lcs_pkg::LCS_DONE) && term_en && !keep_cv_after_done
                      && vbatt_below_rech && in_in_window;
   // Rising input-good, a charge enable edge or auto-recharge may start a cycle.
   assign new_trigger = (s_ff.in_ok && !s_ff.prev_in_ok)
                        || (!charge_disable_n && s_ff.prev_cdis) || auto_rech;
   // Any blocking fault vetoes the trigger.
   assign cycle_ok = new_trigger && !ntc_fault && !s_ff.tmo_flt && !vbatt_ov
                     && !charge_disable_n && s_ff.in_ok;

   // Quiet machine for the checks: no overvoltage, input loss, disable or new cycle.
   logic run_ok;
   assign run_ok = !vbatt_ov && s_ff.in_ok && !charge_disable_n && !cycle_ok;

   // Sequencer, register file and timers in one next-state process.
   always_comb begin
      logic [31:0] wmask;
      wmask = 32'h0;
      nxt_s = s_ff;
      evt   = 4'h0;
      nxt_s.prev_in_ok = s_ff.in_ok;
      nxt_s.prev_cdis  = charge_disable_n;
      nxt_s.prev_iso   = input_isolate_ctl;

      // Input qualification: drop immediately, qualify after the immunity time.
      if (!in_in_window) begin
         nxt_s.in_ok   = 1'b0;
         nxt_s.imm_cnt = 16'h0;
         if (s_ff.in_ok) begin
            evt[`LCS_IRQ_INBAD] = 1'b1;
         end
      end else if (!s_ff.in_ok) begin
         if (32'(s_ff.imm_cnt) >= IMMUNITY_CYC - 1) begin
            nxt_s.in_ok = 1'b1;
         end else begin
            nxt_s.imm_cnt = s_ff.imm_cnt + 16'h1;
         end
      end

      // Safety timer restarts on toggles of the control bits.
      if ((charge_disable_n != s_ff.prev_cdis) || (input_isolate_ctl != s_ff.prev_iso)) begin
         nxt_s.sfty_cnt = 40'h0;
         nxt_s.tmo_flt  = 1'b0;
      end else if (s_ff.chg == lcs_pkg::LCS_PRE) begin
         nxt_s.sfty_cnt = s_ff.sfty_cnt + 40'h1;
      end

      nxt_s.bov_flt = vbatt_ov;
      // Charge state machine.
      if (vbatt_ov && s_ff.chg != lcs_pkg::LCS_IDLE) begin
         nxt_s.chg = lcs_pkg::LCS_FAULT;
         if (!s_ff.bov_flt) begin
            evt[`LCS_IRQ_BOV] = 1'b1;
         end
      end else if (!s_ff.in_ok || charge_disable_n) begin
         nxt_s.chg      = lcs_pkg::LCS_IDLE;
         nxt_s.term_run = 1'b0;
      end else if (cycle_ok) begin
         nxt_s.chg      = lcs_pkg::LCS_PRE;
         nxt_s.sfty_cnt = 40'h0;
         nxt_s.term_run = 1'b0;
      end else begin
         unique case (s_ff.chg)
            lcs_pkg::LCS_IDLE: begin
               nxt_s.chg = s_ff.chg;
            end
            lcs_pkg::LCS_PRE: begin
               if (vbatt_above_pre) begin
                  nxt_s.chg = lcs_pkg::LCS_CC;
               end else if (s_ff.sfty_cnt >= PRE_TMO_CYC - 40'h1) begin
                  nxt_s.chg     = lcs_pkg::LCS_FAULT;
                  nxt_s.tmo_flt = 1'b1;
                  evt[`LCS_IRQ_TMO] = 1'b1;
               end else begin
                  nxt_s.chg = lcs_pkg::LCS_PRE;
               end
            end
            lcs_pkg::LCS_CC: begin
               if (vbatt_at_reg) begin
                  nxt_s.chg = lcs_pkg::LCS_CV;
               end
            end
            lcs_pkg::LCS_CV: begin
               if (!term_en) begin
                  nxt_s.term_run = 1'b0;
               end else if (!s_ff.term_run) begin
                  if (ibatt_below_term) begin
                     nxt_s.term_run = 1'b1;
                     nxt_s.term_cnt = 20'h0;
                  end
               end else if (!ibatt_below_term_hys) begin
                  nxt_s.term_run = 1'b0;
               end else if (32'(s_ff.term_cnt) >= TERM_DLY_CYC - 1) begin
                  nxt_s.term_run = 1'b0;
                  nxt_s.chg      = lcs_pkg::LCS_DONE;
                  evt[`LCS_IRQ_DONE] = 1'b1;
               end else begin
                  nxt_s.term_cnt = s_ff.term_cnt + 20'h1;
               end
            end
            lcs_pkg::LCS_DONE: begin
               nxt_s.chg = s_ff.chg;
            end
            lcs_pkg::LCS_FAULT: begin
               // Overvoltage suspension lifts when the comparator clears.
               if (s_ff.bov_flt && !s_ff.tmo_flt) begin
                  nxt_s.chg = lcs_pkg::LCS_CC;
               end
            end
            default: begin
               nxt_s.chg = lcs_pkg::LCS_IDLE;
            end
         endcase
      end

      // AHB-Lite data phase: write lands, read data was captured in the address phase.
      nxt_s.ph_wr = ahb_go && hwrite;
      nxt_s.ph_rd = ahb_go && !hwrite;
      if (ahb_go) begin
         nxt_s.ph_addr = haddr[7:0];
      end
      if (ahb_go && !hwrite) begin
         unique case (haddr[7:0])
            `LCS_OFS_CHG_CFG:  nxt_s.rdata = s_ff.chg_cfg;
            `LCS_OFS_TERM_CFG: nxt_s.rdata = s_ff.term_cfg;
            `LCS_OFS_STATUS:   nxt_s.rdata = {24'h0, s_ff.bov_flt, s_ff.tmo_flt,
                                              s_ff.in_ok, 2'h0, s_ff.chg};
            `LCS_OFS_IRQ_STAT: nxt_s.rdata = {28'h0, s_ff.irq_stat};
            `LCS_OFS_IRQ_MASK: nxt_s.rdata = {28'h0, s_ff.irq_mask};
            default:           nxt_s.rdata = 32'h0;
         endcase
      end
      if (s_ff.ph_wr) begin
         unique case (s_ff.ph_addr)
            `LCS_OFS_CHG_CFG:  nxt_s.chg_cfg  = hwdata & 32'h03fc_1f03;
            `LCS_OFS_TERM_CFG: nxt_s.term_cfg = hwdata & 32'h0000_0041;
            `LCS_OFS_IRQ_STAT: wmask = hwdata;
            `LCS_OFS_IRQ_MASK: nxt_s.irq_mask = hwdata[3:0];
            default:           wmask = 32'h0;
         endcase
      end
      // Write-one-to-clear; an event in the same cycle wins.
      nxt_s.irq_stat = (s_ff.irq_stat & ~wmask[3:0]) | evt;
   end

   // State register; reset loads every configuration default.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_ff          <= '0;
         s_ff.chg_cfg  <= `LCS_CHG_CFG_RST;
         s_ff.term_cfg <= `LCS_TERM_CFG_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // FET gating: isolate and disable each act on their own path only.
   assign input_pass_fet  = s_ff.in_ok && in_in_window && !input_isolate_ctl;
   // Charge current is cut when complete unless CV is kept.
   assign batt_chg_fet_en = !charge_disable_n && !vbatt_ov && (s_ff.chg == lcs_pkg::LCS_PRE
                            || s_ff.chg == lcs_pkg::LCS_CC || s_ff.chg == lcs_pkg::LCS_CV
                            || (s_ff.chg == lcs_pkg::LCS_DONE && keep_cv_after_done));
   assign pre_current_sel     = s_ff.chg_cfg[`LCS_PRE_LSB +: 2];
   assign cc_current_sel      = s_ff.chg_cfg[`LCS_CC_LSB +: 5];
   assign full_charge_voltage = s_ff.chg_cfg[`LCS_VREG_LSB + 2 +: 6];
   assign chg_state           = s_ff.chg;
   assign chg_done            = (s_ff.chg == lcs_pkg::LCS_DONE);
   assign timeout_fault       = s_ff.tmo_flt;
   assign batt_ov_fault       = s_ff.bov_flt;
   assign irq                 = |(s_ff.irq_stat & s_ff.irq_mask);
   assign hrdata              = s_ff.rdata;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;

   // Checks beside the logic.
   a_ovp_fet_off: assert property (@(posedge core_clk) disable iff (!resetn)
      !in_in_window |-> !input_pass_fet) else $error("input FET on out of window");
   a_iso_fet_off: assert property (@(posedge core_clk) disable iff (!resetn)
      input_isolate_ctl |-> !input_pass_fet) else $error("isolate ignored");
   a_cdis_chg_off: assert property (@(posedge core_clk) disable iff (!resetn)
      charge_disable_n |-> !batt_chg_fet_en) else $error("disable ignored");
   a_bov_suspend: assert property (@(posedge core_clk) disable iff (!resetn)
      vbatt_ov && s_ff.chg != lcs_pkg::LCS_IDLE |=> s_ff.chg == lcs_pkg::LCS_FAULT)
      else $error("overvoltage not suspended");
   a_done_cut: assert property (@(posedge core_clk) disable iff (!resetn)
      chg_done && !keep_cv_after_done |-> !batt_chg_fet_en) else $error("current not cut");
   a_no_term_cv: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CV && !term_en && !vbatt_ov && s_ff.in_ok && !charge_disable_n
      |=> s_ff.chg != lcs_pkg::LCS_DONE) else $error("done without termination");
   a_pre_to_cc: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_PRE && vbatt_above_pre && !vbatt_ov && s_ff.in_ok
      && !charge_disable_n && !cycle_ok |=> s_ff.chg == lcs_pkg::LCS_CC)
      else $error("no fast charge");
   a_cc_to_cv: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CC && vbatt_at_reg && !vbatt_ov && s_ff.in_ok
      && !charge_disable_n && !cycle_ok |=> s_ff.chg == lcs_pkg::LCS_CV)
      else $error("no CV");
   a_rech_gate: assert property (@(posedge core_clk) disable iff (!resetn)
      auto_rech |-> term_en && !keep_cv_after_done) else $error("illegal recharge");
   a_in_ok_rise: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(s_ff.in_ok) |-> $past(in_in_window)) else $error("unqualified input");

   // Input loss clears the qualified flag at the next edge.
   a_in_drop: assert property (@(posedge core_clk) disable iff (!resetn)
      !in_in_window |=> !s_ff.in_ok) else $error("input kept after loss");

   // A short good spell must never qualify the input.
   a_imm_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      !s_ff.in_ok && in_in_window && 32'(s_ff.imm_cnt) < IMMUNITY_CYC - 1
      |=> !s_ff.in_ok) else $error("input qualified early");

   // Pre-charge holds until the threshold or the timer ends it.
   a_pre_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_PRE && !vbatt_above_pre && run_ok
      && s_ff.sfty_cnt < PRE_TMO_CYC - 40'h1 |=> s_ff.chg == lcs_pkg::LCS_PRE)
      else $error("left pre-charge early");

   // Expiry below threshold ends the cycle with a latched timeout.
   a_tmo_fault: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_PRE && !vbatt_above_pre && run_ok
      && s_ff.sfty_cnt >= PRE_TMO_CYC - 40'h1 |=> timeout_fault
      && s_ff.chg == lcs_pkg::LCS_FAULT) else $error("no timeout");

   // Fast charge holds until the full-charge voltage.
   a_cc_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CC && !vbatt_at_reg && run_ok
      |=> s_ff.chg == lcs_pkg::LCS_CC) else $error("left fast charge");

   // The timer is back at zero after a control toggle or a new cycle.
   a_sfty_restart: assert property (@(posedge core_clk) disable iff (!resetn)
      (charge_disable_n != s_ff.prev_cdis) || (input_isolate_ctl != s_ff.prev_iso)
      || cycle_ok |=> s_ff.sfty_cnt == 40'h0) else $error("timer not restarted");

   // Current above threshold plus hysteresis aborts the delay.
   a_term_abort: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CV && term_en && s_ff.term_run && !ibatt_below_term_hys
      && run_ok |=> !s_ff.term_run && !chg_done) else $error("delay not aborted");

   // A full delay with the condition held marks completion.
   a_term_done: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CV && term_en && s_ff.term_run && ibatt_below_term_hys
      && 32'(s_ff.term_cnt) >= TERM_DLY_CYC - 1 && run_ok |=> chg_done)
      else $error("no completion");

   // Without termination the phase stays CV.
   a_cv_stay: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_CV && !term_en && run_ok
      |=> s_ff.chg == lcs_pkg::LCS_CV) else $error("left CV");

   // Kept CV after completion still drives the charge path.
   a_done_keep: assert property (@(posedge core_clk) disable iff (!resetn)
      chg_done && keep_cv_after_done && !vbatt_ov && !charge_disable_n
      |-> batt_chg_fet_en) else $error("kept CV cut");

   // With recharge inhibited, completion stands.
   a_done_stay: assert property (@(posedge core_clk) disable iff (!resetn)
      chg_done && (keep_cv_after_done || !term_en) && run_ok
      |=> chg_done) else $error("inhibited recharge");

   // Blocking faults veto a start from idle.
   a_trig_veto: assert property (@(posedge core_clk) disable iff (!resetn)
      s_ff.chg == lcs_pkg::LCS_IDLE && (ntc_fault || s_ff.tmo_flt || vbatt_ov)
      |=> s_ff.chg != lcs_pkg::LCS_PRE) else $error("vetoed start");

   // Auto-recharge with no blocking fault restarts at pre-charge.
   a_rech_start: assert property (@(posedge core_clk) disable iff (!resetn)
      auto_rech && !ntc_fault && !s_ff.tmo_flt && !vbatt_ov && !charge_disable_n
      |=> s_ff.chg == lcs_pkg::LCS_PRE) else $error("no recharge");

   // The path is cut at once; the flag follows one edge later.
   a_bov_fet: assert property (@(posedge core_clk) disable iff (!resetn)
      vbatt_ov |-> !batt_chg_fet_en) else $error("charging in overvoltage");
   a_bov_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      vbatt_ov |=> batt_ov_fault) else $error("overvoltage not flagged");

   c_done: cover property (@(posedge core_clk) disable iff (!resetn) $rose(chg_done));
   c_tmo: cover property (@(posedge core_clk) disable iff (!resetn) $rose(timeout_fault));
   c_rech: cover property (@(posedge core_clk) disable iff (!resetn) auto_rech && cycle_ok);
   c_keep: cover property (@(posedge core_clk) disable iff (!resetn) chg_done && batt_chg_fet_en);
   c_bov: cover property (@(posedge core_clk) disable iff (!resetn) $rose(batt_ov_fault));

endmodule

/* rtl/lcs_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the charge sequencer.
 * Assumes inclusion by bare name from rtl/, once per compilation unit.
 */
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

// Register byte offsets on the AHB-Lite slave.
`define LCS_OFS_CHG_CFG    8'h00
`define LCS_OFS_TERM_CFG   8'h04
`define LCS_OFS_STATUS     8'h08
`define LCS_OFS_IRQ_STAT   8'h0c
`define LCS_OFS_IRQ_MASK   8'h10

// Charge configuration fields.
`define LCS_PRE_LSB        0
`define LCS_CC_LSB         8
`define LCS_VREG_LSB       16
`define LCS_ISO_BIT        24
`define LCS_CDIS_BIT       25
`define LCS_CHG_CFG_RST    32'h00aa_0f01

// Termination configuration fields.
`define LCS_KEEP_CV_BIT    0
`define LCS_TERM_EN_BIT    6
`define LCS_TERM_CFG_RST   32'h0000_0040

// Interrupt status bits.
`define LCS_IRQ_DONE       0
`define LCS_IRQ_TMO        1
`define LCS_IRQ_BOV        2
`define LCS_IRQ_INBAD      3

// Times in their own units and the derived counts at 250 MHz.
`define LCS_CLK_MHZ        250
`define LCS_IMMUNITY_US    200
`define LCS_IMMUNITY_CYC   (`LCS_IMMUNITY_US * `LCS_CLK_MHZ)
`define LCS_TERM_DLY_NS    2500000
`define LCS_TERM_DLY_CYC   (`LCS_TERM_DLY_NS / 4)
`define LCS_PRE_TMO_S      3600
`define LCS_PRE_TMO_CYC    (64'd3600 * 64'd250000000)

`endif

/* rtl/lcs_pkg.sv */
/*
 * Types of the charge sequencer: charge state encoding and the registered state struct.
 * Assumes lcs_regs.svh is compiled alongside for the numeric constants.
 */
package lcs_pkg;

   // Charge phase, exposed as status.
   typedef enum logic [2:0] {
      LCS_IDLE  = 3'b000,
      LCS_PRE   = 3'b001,
      LCS_CC    = 3'b010,
      LCS_CV    = 3'b011,
      LCS_DONE  = 3'b100,
      LCS_FAULT = 3'b101
   } lcs_chg_t;

   typedef struct packed {
      lcs_chg_t    chg;
      logic [31:0] chg_cfg;
      logic [31:0] term_cfg;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic        in_ok;
      logic [15:0] imm_cnt;
      logic [39:0] sfty_cnt;
      logic [19:0] term_cnt;
      logic        term_run;
      logic        tmo_flt;
      logic        bov_flt;
      logic        prev_in_ok;
      logic        prev_cdis;
      logic        prev_iso;
      logic        ph_rd;
      logic        ph_wr;
      logic [7:0]  ph_addr;
      logic [31:0] rdata;
   } lcs_state_t;

endpackage

/* test/lcs_cell_model.sv */
/*
 * Behavioural cell and input source: turns levels set by the bench into comparator outputs.
 * Assumes the bench changes its levels just after a rising clock edge.
 */
`timescale 1ns/100ps

module lcs_cell_model #(
   parameter int PRE_MV  = 3000,
   parameter int REG_MV  = 4200,
   parameter int RECH_MV = 4040,
   parameter int BOV_MV  = 4330,
   parameter int OVP_MV  = 6000,
   parameter int UVLO_MV = 3800,
   parameter int TERM_MA = 27,
   parameter int HYS_MA  = 10
) (
   input  wire logic [15:0] batt_mv,
   input  wire logic [15:0] chg_ma,
   input  wire logic [15:0] vin_mv,
   input  wire logic        batt_chg_fet_en,
   output logic             vin_ovp,
   output logic             vin_uvlo,
   output logic             vbatt_above_pre,
   output logic             vbatt_at_reg,
   output logic             vbatt_below_rech,
   output logic             vbatt_ov,
   output logic             ibatt_below_term,
   output logic             ibatt_below_term_hys
);
   logic [15:0] ma;

   // No current enters the cell while the charge path is off, so termination may look met.
   assign ma = batt_chg_fet_en ? chg_ma : 16'h0000;
   // Comparator levels; the thresholds are plain defaults, not trimmed silicon values.
   assign vin_ovp              = vin_mv > OVP_MV;
   assign vin_uvlo             = vin_mv < UVLO_MV;
   assign vbatt_above_pre      = batt_mv > PRE_MV;
   assign vbatt_at_reg         = batt_mv >= REG_MV;
   assign vbatt_below_rech     = batt_mv < RECH_MV;
   assign vbatt_ov             = batt_mv > BOV_MV;
   assign ibatt_below_term     = ma < TERM_MA;
   assign ibatt_below_term_hys = ma < TERM_MA + HYS_MA;
endmodule

/* test/lcs_sequencer_tb.sv */
/*
 * Self-checking bench of the charge sequencer: AHB-Lite master tasks, cell model, tests.
 * Assumes rtl/ on the include path and lcs_pkg compiled before this file.
 */
`timescale 1ns/100ps
`include "lcs_regs.svh"

module lcs_sequencer_tb;
   logic        core_clk, resetn, hsel, hwrite, hready, hresp, ntc;
   logic [31:0] haddr, hwdata, hrdata, rdv, cfg;
   logic [1:0]  htrans;
   logic [15:0] batt_mv, chg_ma, vin_mv, seed;
   logic        ovp, uvlo, a_pre, a_reg, b_rech, b_ov, i_term, i_hys;
   logic        fet_in, fet_chg, done, tmo, bov, irq;
   logic [1:0]  pre_sel;
   logic [4:0]  cc_sel;
   logic [5:0]  fcv;
   logic [2:0]  st;
   int          mismatches, samples_checked, n;

   // Short counts keep the run brief; expectations below follow these values.
   lcs_sequencer #(.IMMUNITY_CYC(20), .TERM_DLY_CYC(30), .PRE_TMO_CYC(40'd100)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .vin_ovp(ovp), .vin_uvlo(uvlo),
      .vbatt_above_pre(a_pre), .vbatt_at_reg(a_reg), .vbatt_below_rech(b_rech),
      .vbatt_ov(b_ov), .ibatt_below_term(i_term), .ibatt_below_term_hys(i_hys),
      .ntc_fault(ntc), .input_pass_fet(fet_in), .batt_chg_fet_en(fet_chg),
      .pre_current_sel(pre_sel), .cc_current_sel(cc_sel), .full_charge_voltage(fcv),
      .chg_state(st), .chg_done(done), .timeout_fault(tmo), .batt_ov_fault(bov), .irq(irq));

   lcs_cell_model i_cell (
      .batt_mv(batt_mv), .chg_ma(chg_ma), .vin_mv(vin_mv), .batt_chg_fet_en(fet_chg),
      .vin_ovp(ovp), .vin_uvlo(uvlo), .vbatt_above_pre(a_pre), .vbatt_at_reg(a_reg),
      .vbatt_below_rech(b_rech), .vbatt_ov(b_ov), .ibatt_below_term(i_term),
      .ibatt_below_term_hys(i_hys));

   // Free-running 250 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected pin fields of a configuration word, packed as voltage, fast and pre current.
   function automatic logic [31:0] fields(input logic [31:0] d);
      return {19'h0, d[23:18], d[12:8], d[1:0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic clk(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   // One word transfer; the address phase is held until hready is seen high.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      rdv = hrdata;
      #1;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [31:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   // Cell and source levels change just after an edge; outputs are read once settled.
   task automatic drv(input logic [15:0] b, input logic [15:0] i, input logic [15:0] v);
      @(posedge core_clk);
      batt_mv <= b;
      chg_ma <= i;
      vin_mv <= v;
      #1;
   endtask

   // Polls the charge state under a bound; n keeps the number of cycles waited.
   task automatic wait_st(input logic [2:0] e, input int lim);
      n = 0;
      while (st !== e && n < lim) begin
         clk(1);
         n++;
      end
      chk("chg_state", e, st);
   endtask

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A hang is cut off well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      {mismatches, samples_checked, n} = '0;
      seed = 16'd30488;
      {resetn, hwrite, ntc, htrans, haddr, hwdata} = '0;
      hsel = 1'b1;
      {batt_mv, chg_ma, vin_mv} = {16'd2500, 16'd100, 16'd0};
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      rd(`LCS_OFS_CHG_CFG);
      chk("chg_cfg", `LCS_CHG_CFG_RST, rdv);
      rd(`LCS_OFS_TERM_CFG);
      chk("term_cfg", `LCS_TERM_CFG_RST, rdv);
      rd(32'h0000_0040);
      chk("hole", 32'h0, rdv);
      chk("pins", fields(`LCS_CHG_CFG_RST), {fcv, cc_sel, pre_sel});
      chk("in_fet", 32'h0, fet_in);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(lfsr(seed));
         cfg = {8'h00, seed[5:0], 5'h00, seed[10:6], 6'h00, seed[12:11]};
         wr(`LCS_OFS_CHG_CFG, cfg);
         rd(`LCS_OFS_CHG_CFG);
         chk("cfg_rb", cfg, rdv);
         chk("pins", fields(cfg), {fcv, cc_sel, pre_sel});
      end
      $display("test config done");
      // A short good spell must not start the system; a full one must.
      drv(16'd2500, 16'd100, 16'd5000);
      clk(10);
      drv(16'd2500, 16'd100, 16'd0);
      clk(30);
      chk("glitch", 32'h0, fet_in);
      drv(16'd2500, 16'd100, 16'd5000);
      for (n = 0; fet_in !== 1'b1 && n < 60; n++) clk(1);
      chk("immunity", 32'h1, n >= 19 && n <= 24);
      wait_st(lcs_pkg::LCS_PRE, 5);
      wait_st(lcs_pkg::LCS_FAULT, 120);
      chk("tmo_len", 32'h1, n >= 90 && tmo === 1'b1 && fet_chg === 1'b0);
      wr(`LCS_OFS_CHG_CFG, cfg | (32'h1 << `LCS_CDIS_BIT));
      chk("cdis", 32'h2, {fet_in, fet_chg});
      @(posedge core_clk);
      ntc <= 1'b1;
      wr(`LCS_OFS_CHG_CFG, cfg);
      clk(5);
      chk("ntc_veto", 32'h0, st === lcs_pkg::LCS_PRE);
      @(posedge core_clk);
      ntc <= 1'b0;
      wr(`LCS_OFS_CHG_CFG, cfg | (32'h1 << `LCS_CDIS_BIT));
      wr(`LCS_OFS_CHG_CFG, cfg);
      wait_st(lcs_pkg::LCS_PRE, 8);
      clk(60);
      chk("restart", lcs_pkg::LCS_PRE, st);
      $display("test precharge done");
      drv(16'd3500, 16'd100, 16'd5000);
      wait_st(lcs_pkg::LCS_CC, 5);
      drv(16'd4200, 16'd100, 16'd5000);
      wait_st(lcs_pkg::LCS_CV, 5);
      drv(16'd4200, 16'd20, 16'd5000);
      clk(15);
      drv(16'd4200, 16'd30, 16'd5000);
      clk(5);
      drv(16'd4200, 16'd50, 16'd5000);
      clk(2);
      drv(16'd4200, 16'd20, 16'd5000);
      wait_st(lcs_pkg::LCS_DONE, 45);
      chk("term_len", 32'h1, n >= 26);
      chk("done", 32'h4, {done, fet_chg, irq});
      rd(`LCS_OFS_IRQ_STAT);
      chk("irq_stat", 32'h1, rdv[`LCS_IRQ_DONE]);
      wr(`LCS_OFS_IRQ_MASK, 32'h1);
      clk(2);
      chk("irq_on", 32'h1, irq);
      wr(`LCS_OFS_IRQ_STAT, 32'h1);
      clk(2);
      chk("irq_off", 32'h0, irq);
      drv(16'd4000, 16'd100, 16'd5000);
      wait_st(lcs_pkg::LCS_CC, 5);
      wr(`LCS_OFS_TERM_CFG, 32'h41);
      drv(16'd4200, 16'd20, 16'd5000);
      wait_st(lcs_pkg::LCS_DONE, 50);
      chk("keep_cv", 32'h1, fet_chg);
      drv(16'd4000, 16'd20, 16'd5000);
      clk(10);
      chk("no_rech", lcs_pkg::LCS_DONE, st);
      wr(`LCS_OFS_TERM_CFG, 32'h0);
      wr(`LCS_OFS_CHG_CFG, cfg | (32'h1 << `LCS_CDIS_BIT));
      wr(`LCS_OFS_CHG_CFG, cfg);
      drv(16'd4200, 16'd20, 16'd5000);
      wait_st(lcs_pkg::LCS_CV, 10);
      clk(60);
      chk("no_term", {29'h0, lcs_pkg::LCS_CV}, {done, st});
      $display("test profile done");
      // Overvoltage cuts charge at once; the status word is read-only.
      drv(16'd4400, 16'd20, 16'd5000);
      chk("bov_fet", 32'h0, fet_chg);
      wait_st(lcs_pkg::LCS_FAULT, 3);
      wr(`LCS_OFS_STATUS, 32'hffff_ffff);
      rd(`LCS_OFS_STATUS);
      chk("status", 32'h1d, {bov, rdv[7], rdv[2:0]});
      drv(16'd4200, 16'd20, 16'd7000);
      chk("ovp", 32'h0, fet_in);
      drv(16'd4200, 16'd20, 16'd5000);
      clk(30);
      chk("requal", 32'h1, fet_in);
      wr(`LCS_OFS_CHG_CFG, cfg | (32'h1 << `LCS_ISO_BIT));
      clk(1);
      chk("isolate", 32'h0, fet_in);
      $display("test protect done");
      tally_and_finish();
   end
endmodule
